// File: core/ods_pkg.sv
// package: widths, order codes, register map and states of the order control
package ods_pkg;

  // instruction format
  localparam int WORD_W    = 40;
  localparam int INSTR_W   = 20;
  localparam int ORD_W     = 8;
  localparam int ADDR_W    = 12;
  localparam int ORD_SEL_W = 6;
  localparam int LINE_N    = 36;
  localparam int NIB_HI_B  = 4;
  localparam int NIB_TOP_B = 3;

  // timing generator
  localparam int PULSE_N        = 7;
  localparam int PCNT_W         = 4;
  localparam int PASS_W         = 4;
  localparam int CLK_NS         = 100;
  localparam int FIXED_PULSE_NS = 200;
  // least time, so round up to whole cycles
  localparam int FIXED_PULSE_CYC = (FIXED_PULSE_NS + CLK_NS - 1) / CLK_NS;

  localparam logic [PULSE_N-1:0] PULSE_T1  = 7'h01;
  localparam logic [PULSE_N-1:0] PULSE_T2  = 7'h02;
  localparam logic [PULSE_N-1:0] PULSE_T3  = 7'h04;
  localparam logic [PULSE_N-1:0] PULSE_T7  = 7'h40;
  // t3, t5 and t6 may be stretched
  localparam logic [PULSE_N-1:0] PULSE_VAR = 7'h34;

  // decoder lines that have gates wired in this block
  localparam int LINE_SHIFT      = 1;
  localparam int LINE_JUMP       = 2;
  localparam int LINE_JUMP_RIGHT = 3;
  localparam int LINE_LOAD       = 4;
  localparam int LINE_REPEAT     = 5;
  localparam int LINE_DOUBLE     = 6;

  // wishbone register map, byte addresses
  localparam int WB_ADR_W = 8;
  localparam int WB_DAT_W = 32;
  localparam logic [WB_ADR_W-1:0] REG_CTRL    = 8'h00;
  localparam logic [WB_ADR_W-1:0] REG_STATUS  = 8'h04;
  localparam logic [WB_ADR_W-1:0] REG_CC      = 8'h08;
  localparam logic [WB_ADR_W-1:0] REG_IPR_LO  = 8'h0C;
  localparam logic [WB_ADR_W-1:0] REG_IPR_HI  = 8'h10;
  localparam logic [WB_ADR_W-1:0] REG_DEST_LO = 8'h14;
  localparam logic [WB_ADR_W-1:0] REG_DEST_HI = 8'h18;
  localparam logic [WB_ADR_W-1:0] REG_ACC_LO  = 8'h1C;
  localparam logic [WB_ADR_W-1:0] REG_ACC_HI  = 8'h20;
  localparam logic [WB_ADR_W-1:0] REG_LINE    = 8'h24;
  localparam int CTRL_RUN_B = 0;

  // instruction control states
  typedef enum logic [3:0] {
    SEQ_IDLE  = 4'h1,
    SEQ_FETCH = 4'h2,
    SEQ_START = 4'h4,
    SEQ_EXEC  = 4'h8
  } ods_seq_type;

endpackage

// File: core/ods_top.sv
// module: order decoder, timing pulse generator and instruction control
// What this block does
// - instruction is 20 bits, 8 order, 12 address
// - decoder uses six order bits, nibble tops ignored
// - six bits light at most one of 36 lines
// - seven pulses, four fixed, three variable
// - variable pulse lasts until its operation completes
// - memory access waits for memory's current cycle
// - pulse sequence repeats as often as order needs
// - simple orders end the sequence early
// - actions are static order line AND pulse
// - shift order: first pulse clears destination
// - second pulse sets destination from accumulator
// - fetch clears pair register, reads counter address
// - left half first, then right half
// - start signal begins each instruction's pulses
// - transfer abandons pair, fetches target pair
// - right-half transfer skips fetched left instruction
// - control counter advances once per pair
// - wait for finish before next instruction
// - order gate sets jump pending flag
// - order gate sets jump right half flag
// - repeat input reruns the pulse sequence
// - toggle signal runs sequence exactly twice
`timescale 1ns/1ns
module ods_top
  import ods_pkg::*;
#(
  parameter int PULSE_CYC = FIXED_PULSE_CYC
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [WB_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [WB_DAT_W-1:0] wb_dat_i,
  output logic                     wb_ack_o,
  output logic      [WB_DAT_W-1:0] wb_dat_o,
  input  wire logic                mem_done_i,
  input  wire logic [WORD_W-1:0]   mem_rdata_i,
  output logic                     mem_req_o,
  output logic      [ADDR_W-1:0]   mem_addr_o,
  output logic      [LINE_N-1:0]   order_line_o,
  output logic      [PULSE_N-1:0]  timing_pulse_o,
  output logic                     finish_o
);

  typedef struct packed {
    ods_seq_type         seq;
    logic                run;
    logic [ADDR_W-1:0]   cc;
    logic [WORD_W-1:0]   ipr;
    logic                right_half;
    logic                jump;
    logic                jump_right;
    logic [ADDR_W-1:0]   target;
    logic [LINE_N-1:0]   line;
    logic [PULSE_N-1:0]  pulse;
    logic [PCNT_W-1:0]   pcnt;
    logic [PASS_W-1:0]   pass;
    logic                toggle;
    logic                finish;
    logic                mem_req;
    logic                mem_fetch;
    logic [ADDR_W-1:0]   mem_addr;
    logic                load_done;
    logic                done_s1;
    logic                done_s2;
    logic [WORD_W-1:0]   rd_s1;
    logic [WORD_W-1:0]   rd_s2;
    logic [WORD_W-1:0]   dest;
    logic [WORD_W-1:0]   acc;
    logic                ack;
    logic [WB_DAT_W-1:0] dat;
  } ods_state_type;

  ods_state_type r_reg;
  ods_state_type r_next;

  // top bit of each nibble is always one, so only six bits discriminate
  function automatic logic [ORD_SEL_W-1:0] order_sel(
    input logic [INSTR_W-1:0] ins
  );
    logic [ORD_W-1:0] ord;
    ord = ins[INSTR_W-1 -: ORD_W];
    order_sel = {ord[NIB_HI_B+NIB_TOP_B-1:NIB_HI_B],
                 ord[NIB_TOP_B-1:0]};
  endfunction

  // 36 coincidence gates; patterns past the last gate light nothing
  function automatic logic [LINE_N-1:0] decode_line(
    input logic [ORD_SEL_W-1:0] sel
  );
    decode_line = '0;
    for (int i = 0; i < LINE_N; i++) begin
      if (sel == ORD_SEL_W'(i)) begin
        decode_line[i] = 1'b1;
      end
    end
  endfunction

  // simple orders stop after their last useful pulse
  function automatic logic [PULSE_N-1:0] last_pulse(
    input logic [LINE_N-1:0] line
  );
    if (line[LINE_JUMP] || line[LINE_JUMP_RIGHT]) begin
      last_pulse = PULSE_T1;
    end else if (line[LINE_SHIFT] || line[LINE_REPEAT] ||
                 line[LINE_DOUBLE]) begin
      last_pulse = PULSE_T2;
    end else if (line[LINE_LOAD]) begin
      last_pulse = PULSE_T3;
    end else begin
      last_pulse = PULSE_T7;
    end
  endfunction

  // byte lane merge for wishbone writes
  function automatic logic [WB_DAT_W-1:0] merge(
    input logic [WB_DAT_W-1:0] old,
    input logic [WB_DAT_W-1:0] wd,
    input logic [3:0]          sel
  );
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        merge[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
  endfunction

  logic [INSTR_W-1:0]  cur_instr;
  logic [ADDR_W-1:0]   cur_addr;
  logic                hold;
  logic                cycle_in;
  logic [WB_DAT_W-1:0] status_word;

  // current half of the pair feeds decoder and address path
  assign cur_instr = r_reg.right_half ? r_reg.ipr[INSTR_W-1:0]
                                      : r_reg.ipr[WORD_W-1:INSTR_W];
  assign cur_addr  = cur_instr[ADDR_W-1:0];

  // a variable pulse stays on while its memory action is open
  assign hold = (|(r_reg.pulse & PULSE_VAR)) &&
                r_reg.line[LINE_LOAD] && !r_reg.load_done;

  // rerun request: counted repeat or the one-shot double toggle
  assign cycle_in = (r_reg.line[LINE_REPEAT] &&
                     r_reg.pass < cur_addr[PASS_W-1:0]) ||
                    (r_reg.line[LINE_DOUBLE] && !r_reg.toggle);

  assign status_word = WB_DAT_W'({r_reg.mem_req, r_reg.right_half,
                                  r_reg.jump_right, r_reg.jump,
                                  r_reg.pulse, r_reg.seq});

  // next state of the whole block
  always_comb begin
    r_next        = r_reg;
    r_next.finish = 1'b0;
    r_next.ack    = 1'b0;

    // memory handshake and data come from a self-timed unit
    r_next.done_s1 = mem_done_i;
    r_next.done_s2 = r_reg.done_s1;
    r_next.rd_s1   = mem_rdata_i;
    r_next.rd_s2   = r_reg.rd_s1;

    // decoder output is registered, then held static for the gates
    r_next.line = decode_line(order_sel(cur_instr));

    // wishbone slave, one wait state, unmapped reads give zero
    // a read is latched when taken; a write lands where ack is seen
    if (wb_cyc_i && wb_stb_i) begin
      if (!r_reg.ack) begin
        r_next.ack = 1'b1;
      end
      if (wb_we_i && r_reg.ack) begin
        case (wb_adr_i)
          REG_CTRL: begin
            if (wb_sel_i[0]) begin
              r_next.run = wb_dat_i[CTRL_RUN_B];
            end
          end
          REG_CC: begin
            if (r_reg.seq == SEQ_IDLE) begin
              r_next.cc = ADDR_W'(merge(WB_DAT_W'(r_reg.cc), wb_dat_i,
                                        wb_sel_i));
            end
          end
          REG_ACC_LO: begin
            if (r_reg.seq == SEQ_IDLE) begin
              r_next.acc[WB_DAT_W-1:0] =
                merge(r_reg.acc[WB_DAT_W-1:0], wb_dat_i, wb_sel_i);
            end
          end
          REG_ACC_HI: begin
            if (r_reg.seq == SEQ_IDLE) begin
              r_next.acc[WORD_W-1:WB_DAT_W] = (WORD_W - WB_DAT_W)'(
                merge(WB_DAT_W'(r_reg.acc[WORD_W-1:WB_DAT_W]),
                      wb_dat_i, wb_sel_i));
            end
          end
          default: begin
          end
        endcase
      end else if (!wb_we_i && !r_reg.ack) begin
        case (wb_adr_i)
          REG_CTRL:    r_next.dat = WB_DAT_W'(r_reg.run);
          REG_STATUS:  r_next.dat = status_word;
          REG_CC:      r_next.dat = WB_DAT_W'(r_reg.cc);
          REG_IPR_LO:  r_next.dat = WB_DAT_W'(r_reg.ipr[INSTR_W-1:0]);
          REG_IPR_HI:  r_next.dat = WB_DAT_W'(r_reg.ipr[WORD_W-1:INSTR_W]);
          REG_DEST_LO: r_next.dat = r_reg.dest[WB_DAT_W-1:0];
          REG_DEST_HI: r_next.dat = WB_DAT_W'(r_reg.dest[WORD_W-1:WB_DAT_W]);
          REG_ACC_LO:  r_next.dat = r_reg.acc[WB_DAT_W-1:0];
          REG_ACC_HI:  r_next.dat = WB_DAT_W'(r_reg.acc[WORD_W-1:WB_DAT_W]);
          REG_LINE:    r_next.dat = WB_DAT_W'(r_reg.line);
          default:     r_next.dat = '0;
        endcase
      end
    end

    // memory answer; req drops and waits for done to fall again
    if (r_reg.mem_req && r_reg.done_s2) begin
      r_next.mem_req = 1'b0;
      if (r_reg.mem_fetch) begin
        r_next.ipr        = r_reg.rd_s2;
        r_next.cc         = r_reg.cc + 1'b1;
        r_next.right_half = r_reg.jump_right;
        r_next.jump       = 1'b0;
        r_next.jump_right = 1'b0;
        r_next.seq        = SEQ_START;
      end else begin
        r_next.acc       = r_reg.rd_s2;
        r_next.load_done = 1'b1;
      end
    end

    // instruction control
    case (r_reg.seq)
      SEQ_IDLE: begin
        if (r_reg.run) begin
          r_next.seq = SEQ_FETCH;
          r_next.ipr = '0;
        end
      end
      SEQ_FETCH: begin
        // no new access until the memory has closed its last one
        if (!r_reg.mem_req && !r_reg.done_s2) begin
          r_next.mem_req   = 1'b1;
          r_next.mem_fetch = 1'b1;
          r_next.mem_addr  = r_reg.cc;
        end
      end
      SEQ_START: begin
        r_next.seq       = SEQ_EXEC;
        r_next.pulse     = PULSE_T1;
        r_next.pcnt      = '0;
        r_next.pass      = '0;
        r_next.toggle    = 1'b0;
        r_next.load_done = 1'b0;
      end
      SEQ_EXEC: begin
        if (r_reg.finish) begin
          if (r_reg.jump) begin
            r_next.cc  = r_reg.target;
            if (r_reg.run) begin
              r_next.seq = SEQ_FETCH;
              r_next.ipr = '0;
            end else begin
              // a stop request must also end a transfer loop
              r_next.seq = SEQ_IDLE;
            end
          end else if (!r_reg.right_half) begin
            r_next.right_half = 1'b1;
            r_next.seq        = SEQ_START;
          end else if (r_reg.run) begin
            r_next.seq = SEQ_FETCH;
            r_next.ipr = '0;
          end else begin
            r_next.seq = SEQ_IDLE;
          end
        end
      end
      default: begin
        r_next.seq = SEQ_IDLE;
      end
    endcase

    // order gates: static decoder line AND one timed pulse
    if (r_reg.pulse != '0) begin
      if (r_reg.line[LINE_SHIFT] && r_reg.pulse[0]) begin
        r_next.dest = '0;
      end
      if (r_reg.line[LINE_SHIFT] && r_reg.pulse[1]) begin
        r_next.dest = r_reg.dest | (r_reg.acc << 1);
      end
      // accumulator shift once per pass, on the pulse's first cycle
      if ((r_reg.line[LINE_REPEAT] || r_reg.line[LINE_DOUBLE]) &&
          r_reg.pulse[1] && r_reg.pcnt == '0) begin
        r_next.acc = r_reg.acc << 1;
      end
      if (r_reg.line[LINE_JUMP] && r_reg.pulse[0]) begin
        r_next.jump   = 1'b1;
        r_next.target = cur_addr;
      end
      if (r_reg.line[LINE_JUMP_RIGHT] && r_reg.pulse[0]) begin
        r_next.jump       = 1'b1;
        r_next.jump_right = 1'b1;
        r_next.target     = cur_addr;
      end
      if (r_reg.line[LINE_LOAD] && r_reg.pulse[2] && !r_reg.mem_req &&
          !r_reg.load_done && !r_reg.done_s2) begin
        r_next.mem_req   = 1'b1;
        r_next.mem_fetch = 1'b0;
        r_next.mem_addr  = cur_addr;
      end

      // pulse stepping: fixed length, stretched while held
      if (r_reg.pcnt != PCNT_W'(PULSE_CYC - 1)) begin
        r_next.pcnt = r_reg.pcnt + 1'b1;
      end else if (!hold) begin
        r_next.pcnt = '0;
        if ((r_reg.pulse & last_pulse(r_reg.line)) != '0) begin
          if (cycle_in) begin
            r_next.pulse     = PULSE_T1;
            r_next.pass      = r_reg.pass + 1'b1;
            r_next.toggle    = 1'b1;
            r_next.load_done = 1'b0;
          end else begin
            r_next.pulse  = '0;
            r_next.finish = 1'b1;
          end
        end else begin
          r_next.pulse = r_reg.pulse << 1;
        end
      end
    end
  end

  // single state register; reset leaves the machine idle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg     <= '0;
      r_reg.seq <= SEQ_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  assign wb_ack_o       = r_reg.ack;
  assign wb_dat_o       = r_reg.dat;
  assign mem_req_o      = r_reg.mem_req;
  assign mem_addr_o     = r_reg.mem_addr;
  assign order_line_o   = r_reg.line;
  assign timing_pulse_o = r_reg.pulse;
  assign finish_o       = r_reg.finish;

  // checks on the control sequence
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_fetch_done;
    r_reg.seq == SEQ_FETCH && r_reg.mem_req && r_reg.done_s2;
  endsequence

  sequence s_shift_t1;
    r_reg.line[LINE_SHIFT] && r_reg.pulse == PULSE_T1;
  endsequence

  chk_decode_line: assert property (
    !$past(rst_i) |->
      r_reg.line == decode_line(order_sel($past(cur_instr))))
    else $error("decoder line does not match order bits");

  chk_line_single: assert property (
    $onehot0(order_line_o))
    else $error("more than one decoder line active");

  chk_shift_clear: assert property (
    s_shift_t1 ##0 (r_reg.pcnt == '0) |=> r_reg.dest == '0)
    else $error("first pulse did not clear destination");

  chk_shift_set: assert property (
    s_shift_t1 ##1 (r_reg.pulse == PULSE_T2) |=>
      r_reg.dest == ($past(r_reg.acc) << 1))
    else $error("second pulse did not copy shifted accumulator");

  chk_fetch_clear: assert property (
    $rose(r_reg.seq == SEQ_FETCH) |-> r_reg.ipr == '0)
    else $error("pair register not cleared on fetch");

  chk_cc_advance: assert property (
    s_fetch_done |=> r_reg.cc == $past(r_reg.cc) + 1'b1 &&
                     r_reg.seq == SEQ_START)
    else $error("control counter not advanced after fetch");

  chk_start_pulse: assert property (
    r_reg.seq == SEQ_START |=> r_reg.pulse == PULSE_T1)
    else $error("start did not raise first pulse");

  chk_var_hold: assert property (
    (r_reg.pulse == PULSE_T3 && hold) |=> r_reg.pulse == PULSE_T3)
    else $error("variable pulse ended before completion");

  chk_mem_wait: assert property (
    $rose(r_reg.mem_req) |-> $past(!r_reg.done_s2))
    else $error("request raised while memory still busy");

  chk_finish_wait: assert property (
    (r_reg.seq == SEQ_EXEC && !r_reg.finish) |=> r_reg.seq == SEQ_EXEC)
    else $error("moved on before finish");

  chk_jump_refetch: assert property (
    (r_reg.seq == SEQ_EXEC && r_reg.finish && r_reg.jump &&
     r_reg.run) |=>
      r_reg.seq == SEQ_FETCH && r_reg.cc == $past(r_reg.target))
    else $error("transfer did not refetch target pair");

  chk_short_jump: assert property (
    (r_reg.line[LINE_JUMP] && r_reg.pulse == PULSE_T1 && !hold &&
     r_reg.pcnt == PCNT_W'(PULSE_CYC - 1)) |=>
      r_reg.pulse == '0 && r_reg.finish)
    else $error("transfer order ran past its first pulse");

endmodule

// File: sim/ods_mem_model.sv
// memory unit model: refresh-gated four-phase read handshake
`timescale 1ns/1ns
module ods_mem_model
  import ods_pkg::*;
#(
  parameter int REFRESH_CYC = 5,
  parameter int ACCESS_CYC  = 2
) (
  input  wire logic              clk_i,
  input  wire logic              mem_req_i,
  input  wire logic [ADDR_W-1:0] mem_addr_i,
  output logic                   mem_done_o,
  output logic      [WORD_W-1:0] mem_rdata_o
);
  logic [WORD_W-1:0] mem_array [0:(1<<ADDR_W)-1];
  int                refresh_cnt = 0;

  initial begin
    mem_done_o  = 1'b0;
    mem_rdata_o = {WORD_W{1'b0}};
  end

  // free-running regeneration, on the falling edge to stay clear of the
  // design's sampling edge
  always @(negedge clk_i) begin
    refresh_cnt <= (refresh_cnt + 1) % REFRESH_CYC;
  end

  // a read waits for the running refresh to end, so its length varies
  always begin
    @(negedge clk_i);
    if (mem_req_i === 1'b1) begin
      while (refresh_cnt != 0) @(negedge clk_i);
      repeat (ACCESS_CYC) @(negedge clk_i);
      mem_rdata_o <= mem_array[mem_addr_i];
      mem_done_o  <= 1'b1;
      @(negedge clk_i);
      while (mem_req_i === 1'b1) @(negedge clk_i);
      mem_done_o  <= 1'b0;
      // released data line must not look valid
      mem_rdata_o <= ~mem_rdata_o;
    end
  end
endmodule

// File: sim/ods_top_tb.sv
// testbench: register access, program run and result checks for ods_top
`timescale 1ns/1ns
module ods_top_tb;
  import ods_pkg::*;
  localparam int PULSE_CYC_TB = 2;
  logic                clk_i;
  logic                rst_i;
  logic                wb_cyc_i;
  logic                wb_stb_i;
  logic                wb_we_i;
  logic [WB_ADR_W-1:0] wb_adr_i;
  logic [3:0]          wb_sel_i;
  logic [WB_DAT_W-1:0] wb_dat_i;
  logic                wb_ack_o;
  logic [WB_DAT_W-1:0] wb_dat_o;
  logic                mem_done_i;
  logic [WORD_W-1:0]   mem_rdata_i;
  logic                mem_req_o;
  logic [ADDR_W-1:0]   mem_addr_o;
  logic [LINE_N-1:0]   order_line_o;
  logic [PULSE_N-1:0]  timing_pulse_o;
  logic                finish_o;
  logic [WB_DAT_W-1:0] rd;
  int                  err_total = 0;
  int                  samples_checked = 0;
  int                  t3_run = 0;
  int                  t3_max = 0;

  ods_top #(.PULSE_CYC(PULSE_CYC_TB)) i_ods_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .mem_done_i(mem_done_i),
    .mem_rdata_i(mem_rdata_i), .mem_req_o(mem_req_o),
    .mem_addr_o(mem_addr_o), .order_line_o(order_line_o),
    .timing_pulse_o(timing_pulse_o), .finish_o(finish_o)
  );

  ods_mem_model i_ods_mem_model (
    .clk_i(clk_i), .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o),
    .mem_done_o(mem_done_i), .mem_rdata_o(mem_rdata_i)
  );

  // 10 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [WB_DAT_W-1:0] seen,
                       input logic [WB_DAT_W-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one classic cycle; request held until ack is sampled at a rising edge
  task automatic wb_cycle(input logic we, input logic [WB_ADR_W-1:0] adr,
                          input logic [WB_DAT_W-1:0] wd);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) begin
      err_total++;
      final_report();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk_i);
  endtask

  // bounded poll of a register field
  task automatic poll(input logic [WB_ADR_W-1:0] adr,
                      input logic [WB_DAT_W-1:0] mask,
                      input logic [WB_DAT_W-1:0] val);
    int n;
    n = 0;
    do begin
      wb_cycle(1'b0, adr, 32'h0);
      n++;
    end while ((rd & mask) !== val && n < 3000);
    if (n >= 3000) begin
      err_total++;
      final_report();
    end
  endtask

  // pulses and decoder lines never show two bits; track t3 length
  always @(negedge clk_i) begin
    if (rst_i === 1'b0) begin
      check("pulse_onehot", {31'h0, $onehot0(timing_pulse_o)}, 32'h1);
      check("line_onehot", {31'h0, $onehot0(order_line_o)}, 32'h1);
      t3_run = (timing_pulse_o[2] === 1'b1) ? t3_run + 1 : 0;
      if (t3_run > t3_max) t3_max = t3_run;
    end
  end

  initial begin
    rst_i    = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i  = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    // program: shift, load, right-half jump, repeat, jump-to-self loop
    i_ods_mem_model.mem_array[12'h010] = {20'h89000, 20'h8C020};
    i_ods_mem_model.mem_array[12'h011] = {20'h8B013, 20'h89000};
    i_ods_mem_model.mem_array[12'h012] = {20'h8C021, 20'h8C021};
    i_ods_mem_model.mem_array[12'h013] = {20'h8C021, 20'h8D002};
    i_ods_mem_model.mem_array[12'h014] = {20'h8A014, 20'h8E000};
    i_ods_mem_model.mem_array[12'h020] = 40'h123456789A;
    i_ods_mem_model.mem_array[12'h021] = 40'hFFFFFFFFFF;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_cycle(1'b0, REG_STATUS, 32'h0);
    check("status_idle", rd, 32'h1);
    wb_cycle(1'b0, 8'h3C, 32'h0);
    check("unmapped", rd, 32'h0);
    wb_cycle(1'b1, REG_CC, 32'h010);
    wb_cycle(1'b1, REG_ACC_LO, 32'h3);
    wb_cycle(1'b1, REG_ACC_HI, 32'h0);
    wb_cycle(1'b0, REG_CC, 32'h0);
    check("cc_start", rd, 32'h010);
    wb_cycle(1'b1, REG_CTRL, 32'h1);
    // counter reaches one past the looping pair
    poll(REG_CC, 32'hFFF, 32'h015);
    // busy: accumulator write must be ignored
    wb_cycle(1'b1, REG_ACC_LO, 32'h5555);
    wb_cycle(1'b1, REG_CTRL, 32'h0);
    poll(REG_STATUS, 32'hF, 32'h1);
    wb_cycle(1'b0, REG_ACC_LO, 32'h0);
    check("acc_lo", rd, 32'hA2B3C4D0);
    wb_cycle(1'b0, REG_ACC_HI, 32'h0);
    check("acc_hi", rd, 32'h91);
    wb_cycle(1'b0, REG_DEST_LO, 32'h0);
    check("dest_lo", rd, 32'h6);
    wb_cycle(1'b0, REG_DEST_HI, 32'h0);
    check("dest_hi", rd, 32'h0);
    wb_cycle(1'b0, REG_IPR_HI, 32'h0);
    check("ipr_left", rd, 32'h8A014);
    wb_cycle(1'b0, REG_IPR_LO, 32'h0);
    check("ipr_right", rd, 32'h8E000);
    wb_cycle(1'b0, REG_CC, 32'h0);
    check("cc_end", rd, 32'h014);
    check("t3_stretch", {31'h0, t3_max > PULSE_CYC_TB}, 32'h1);
    final_report();
  end
endmodule
